// ---- design/pswc_map.svh ----
`ifndef PSWC_MAP_SVH
`define PSWC_MAP_SVH

// Register offsets (byte addresses, word aligned)
`define PSWC_OFS_CTRL 8'h00
`define PSWC_OFS_TEST 8'h04
`define PSWC_OFS_PERIOD 8'h08
`define PSWC_OFS_COUNT 8'h0c
`define PSWC_OFS_STATUS 8'h10
`define PSWC_OFS_MASK 8'h14
`define PSWC_OFS_FAULT 8'h18

// Control fields
`define PSWC_CTRL_POWER_DOWN_REQUEST 0
// Test config fields
`define PSWC_TEST_CRST_OFF 0
`define PSWC_TEST_DIG_ARM 1
// Status fields
`define PSWC_ST_STATE_LO 0
`define PSWC_ST_TSD_A 2
`define PSWC_ST_TSD_B 3
`define PSWC_ST_DIG_ARMED 4
`define PSWC_ST_TONE 5
// Fault/mask fields
`define PSWC_FLT_COMM 0
`define PSWC_FLT_SYS 1

// Reset values
`define PSWC_RST_PERIOD 24'h00_0000
`define PSWC_RST_MASK 2'h0

// Timing
`define PSWC_CLK_MHZ 100
`define PSWC_TICK_HZ 4000
`define PSWC_TICK_DIV ((`PSWC_CLK_MHZ * 1000000) / `PSWC_TICK_HZ)
`define PSWC_TONE_NS 1000
`define PSWC_TONE_CYC ((`PSWC_TONE_NS * `PSWC_CLK_MHZ) / 1000)
`define PSWC_IO_SD_NS 5000
`define PSWC_IO_SD_CYC ((`PSWC_IO_SD_NS * `PSWC_CLK_MHZ) / 1000)
`define PSWC_REG_SD_NS 5000
`define PSWC_REG_SD_CYC ((`PSWC_REG_SD_NS * `PSWC_CLK_MHZ) / 1000)

`endif

// ---- design/pswc_pkg.sv ----
package pswc_pkg;
    typedef enum logic [1:0] {
        PSWC_SLEEP,
        PSWC_IDLE,
        PSWC_ACTIVE
    } pswc_state_e;
endpackage

// ---- design/pswc_delay_filter.sv ----
`timescale 1ns/1ns
// Asserts held_r once cond stays high longer than DELAY cycles
module pswc_delay_filter #(
    parameter int DELAY = 500
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Condition
    input wire logic clr,
    input wire logic cond,
    output logic held_r
);
    localparam int W = $clog2(DELAY + 2);
    logic [W-1:0] cnt_r;

    initial
    begin
        if (DELAY < 1)
            $error("pswc_delay_filter: DELAY must be at least 1");
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            cnt_r <= '0;
            held_r <= 1'b0;
        end
        else if (clr || !cond)
        begin
            cnt_r <= '0;
            held_r <= 1'b0;
        end
        else if (cnt_r > W'(DELAY - 1))
            held_r <= 1'b1;
        else
            cnt_r <= cnt_r + W'(1);
    end
endmodule

// ---- design/pswc_core.sv ----
`timescale 1ns/1ns
`include "pswc_map.svh"
// Contract
// [RL1] Three states: sleep, idle, active
// [RL2] Active only during traffic, else idle
// [RL3] Wake pin high or tone wakes
// [RL4] Power-down bit enters sleep
// [RL5] Comm timeout with no frames sleeps
// [RL6] Reset-disable bit: expiry always sleeps
// [RL7] Armed digital test plus low supply sleeps
// [RL8] Digital test arm sticky until sleep
// [RL9] Either thermal sensor sleeps, own flag
// [RL10] IO supply drop resets; long drop sleeps
// [RL11] 5V low or regulator timeout sleeps
// [RL12] Main or digital supply loss sleeps
// [RL13] Wake pin high: shutdown bounces awake
// [RL14] Wake pin low alone never sleeps
// [RL15] 4 kHz counter, top 24 bits accessible
// [RL16] Count write sets low bits ones
// [RL17] Reset-disable: traffic keeps counter running
// [RL18] Comm errors flag only when masked-in
// [RL19] Leaving sleep sends upward wake tone
// [RL20] Power-down with wake high rewakes
// [RL21] Wakeup fully resets control state
// [RL22] Valid frame reloads timeout counter
// [RL23] Shutdown beats other changes unless waking
module pswc_core #(
    parameter int CNT_LOW = 8,
    parameter int TICK_DIV = `PSWC_TICK_DIV,
    parameter int TONE_CYC = `PSWC_TONE_CYC,
    parameter int IO_SD_CYC = `PSWC_IO_SD_CYC,
    parameter int REG_SD_CYC = `PSWC_REG_SD_CYC
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Avalon-MM slave
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Link activity
    input wire logic wake_pin,
    input wire logic low_side_link_tone,
    input wire logic frame_valid,
    input wire logic comm_busy,
    input wire logic comm_bit_error,
    input wire logic sys_bit_error,
    // Supply and thermal monitors
    input wire logic io_supply_low,
    input wire logic main_supply_low,
    input wire logic digital_supply_low,
    input wire logic always_on_5v_supply_low,
    input wire logic regulator_drive,
    input wire logic thermal_shutdown_sensor_a,
    input wire logic thermal_shutdown_sensor_b,
    // Power outputs
    output logic high_side_link_tone,
    output logic core_reset_r,
    output logic awake_r,
    output logic [1:0] state_out_r
);
    localparam int CW = 24 + CNT_LOW;
    localparam int TW = $clog2(TICK_DIV + 1);
    localparam int NW = $clog2(TONE_CYC + 1);

    initial
    begin
        if (CNT_LOW < 1 || CNT_LOW > 8 || TICK_DIV < 2 || TONE_CYC < 1)
            $error("pswc_core: unsupported parameter values");
    end

    pswc_pkg::pswc_state_e state_r;
    pswc_pkg::pswc_state_e state_nxt;
    logic power_down_request_r;
    logic crst_off_r;
    logic dig_arm_r;
    logic [23:0] period_r;
    logic [CW-1:0] cnt_r;
    logic [TW-1:0] tick_cnt_r;
    logic tick;
    logic tsd_a_r;
    logic tsd_b_r;
    logic [1:0] mask_r;
    logic [1:0] fault_r;
    logic [NW-1:0] tone_cnt_r;
    logic ack_r;
    logic io_sd;
    logic reg_sd;
    logic shutdown;
    logic wake;
    logic wr_ctrl;
    logic wr_test;
    logic wr_period;
    logic wr_count;
    logic wr_fault;
    logic expired;

    ////////////////////////////////////////////////////////////////////////
    // Supply delay filters
    pswc_delay_filter #(
        .DELAY(IO_SD_CYC)
    ) u_io_sd (
        .clk_sys(clk_sys),
        .rst(rst),
        .clr(1'b0),
        .cond(io_supply_low),
        .held_r(io_sd)
    );

    pswc_delay_filter #(
        .DELAY(REG_SD_CYC)
    ) u_reg_sd (
        .clk_sys(clk_sys),
        .rst(rst),
        .clr(1'b0),
        .cond(regulator_drive && main_supply_low),
        .held_r(reg_sd)
    );

    ////////////////////////////////////////////////////////////////////////
    // Bus access: one wait cycle, answer on second edge
    wire logic req = (avs_read || avs_write) && !ack_r;
    assign wr_ctrl = avs_write && ack_r && avs_address == `PSWC_OFS_CTRL;
    assign wr_test = avs_write && ack_r && avs_address == `PSWC_OFS_TEST;
    assign wr_period = avs_write && ack_r && avs_address == `PSWC_OFS_PERIOD;
    assign wr_count = avs_write && ack_r && avs_address == `PSWC_OFS_COUNT;
    assign wr_fault = avs_write && ack_r && avs_address == `PSWC_OFS_FAULT;
    wire logic wr_mask = avs_write && ack_r && avs_address == `PSWC_OFS_MASK;

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            ack_r <= 1'b0;
            avs_waitrequest <= 1'b1;
        end
        else
        begin
            ack_r <= req;
            avs_waitrequest <= !req;
        end
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            avs_readdata <= 32'h0000_0000;
        else if (req && avs_read)
        begin
            case (avs_address)
                `PSWC_OFS_CTRL: avs_readdata <= {31'h0, power_down_request_r};
                `PSWC_OFS_TEST: avs_readdata <= {31'h0, crst_off_r};
                `PSWC_OFS_PERIOD: avs_readdata <= {8'h00, period_r};
                `PSWC_OFS_COUNT: avs_readdata <= {8'h00, cnt_r[CW-1 -: 24]};
                `PSWC_OFS_STATUS: avs_readdata <= {26'h0, high_side_link_tone,
                    dig_arm_r, tsd_b_r, tsd_a_r, state_r}; // [RL9]
                `PSWC_OFS_MASK: avs_readdata <= {30'h0, mask_r};
                `PSWC_OFS_FAULT: avs_readdata <= {30'h0, fault_r};
                default: avs_readdata <= 32'h0000_0000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Control and test registers, cleared on sleep
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            power_down_request_r <= 1'b0;
            crst_off_r <= 1'b0;
            dig_arm_r <= 1'b0;
            period_r <= `PSWC_RST_PERIOD;
            mask_r <= `PSWC_RST_MASK;
        end
        else if (state_r == pswc_pkg::PSWC_SLEEP)
        begin
            power_down_request_r <= 1'b0; // [RL21]
            crst_off_r <= 1'b0;
            dig_arm_r <= 1'b0; // [RL8]
            period_r <= `PSWC_RST_PERIOD;
            mask_r <= `PSWC_RST_MASK;
        end
        else
        begin
            if (wr_ctrl)
                power_down_request_r <= avs_writedata[`PSWC_CTRL_POWER_DOWN_REQUEST]; // [RL4]
            if (wr_test)
            begin
                crst_off_r <= avs_writedata[`PSWC_TEST_CRST_OFF];
                if (avs_writedata[`PSWC_TEST_DIG_ARM])
                    dig_arm_r <= 1'b1; // [RL8]
            end
            if (wr_period)
                period_r <= avs_writedata[23:0];
            if (wr_mask)
                mask_r <= avs_writedata[1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // 4 kHz tick and timeout counter
    assign tick = tick_cnt_r == TW'(TICK_DIV - 1);

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            tick_cnt_r <= '0;
        else if (tick)
            tick_cnt_r <= '0;
        else
            tick_cnt_r <= tick_cnt_r + TW'(1); // [RL15]
    end

    assign expired = period_r != 24'h0 && cnt_r[CW-1 -: 24] >= period_r;

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            cnt_r <= '0;
        else if (state_r == pswc_pkg::PSWC_SLEEP)
            cnt_r <= '0; // [RL21]
        else if (wr_count)
            cnt_r <= {avs_writedata[23:0], {CNT_LOW{1'b1}}}; // [RL16]
        else if (frame_valid && !crst_off_r)
            cnt_r <= '0; // [RL22] [RL17]
        else if (tick)
            cnt_r <= cnt_r + CW'(1); // [RL15]
    end

    ////////////////////////////////////////////////////////////////////////
    // Thermal and bit-error flags, set wins over clear, except that sleep clears the bit-error flags
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            tsd_a_r <= 1'b0;
            tsd_b_r <= 1'b0;
        end
        else
        begin
            tsd_a_r <= thermal_shutdown_sensor_a ||
                (tsd_a_r && state_r != pswc_pkg::PSWC_SLEEP); // [RL9]
            tsd_b_r <= thermal_shutdown_sensor_b ||
                (tsd_b_r && state_r != pswc_pkg::PSWC_SLEEP); // [RL9]
        end
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            fault_r <= 2'h0;
        else if (state_r == pswc_pkg::PSWC_SLEEP)
            fault_r <= 2'h0;
        else
        begin
            fault_r[`PSWC_FLT_COMM] <= (comm_bit_error && mask_r[`PSWC_FLT_COMM]) ||
                (fault_r[`PSWC_FLT_COMM] && !(wr_fault &&
                avs_writedata[`PSWC_FLT_COMM])); // [RL18]
            fault_r[`PSWC_FLT_SYS] <= (sys_bit_error && mask_r[`PSWC_FLT_SYS]) ||
                (fault_r[`PSWC_FLT_SYS] && !(wr_fault &&
                avs_writedata[`PSWC_FLT_SYS])); // [RL18]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Shutdown and wake decision
    always_comb
    begin
        shutdown = power_down_request_r // [RL4]
            || expired // [RL5] [RL6]
            || (dig_arm_r && digital_supply_low) // [RL7]
            || tsd_a_r || tsd_b_r // [RL9]
            || io_sd // [RL10]
            || always_on_5v_supply_low || reg_sd // [RL11]
            || main_supply_low || digital_supply_low; // [RL12]
        wake = wake_pin || low_side_link_tone; // [RL3] [RL13]
    end

    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            pswc_pkg::PSWC_SLEEP:
                if (wake)
                    state_nxt = pswc_pkg::PSWC_IDLE; // [RL3] [RL20]
            pswc_pkg::PSWC_IDLE:
                if (shutdown)
                    state_nxt = pswc_pkg::PSWC_SLEEP; // [RL23] [RL14]
                else if (comm_busy)
                    state_nxt = pswc_pkg::PSWC_ACTIVE; // [RL2]
            pswc_pkg::PSWC_ACTIVE:
                if (shutdown)
                    state_nxt = pswc_pkg::PSWC_SLEEP; // [RL23]
                else if (!comm_busy)
                    state_nxt = pswc_pkg::PSWC_IDLE; // [RL2]
            default:
                state_nxt = pswc_pkg::PSWC_SLEEP;
        endcase
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            state_r <= pswc_pkg::PSWC_SLEEP;
        else
            state_r <= state_nxt; // [RL1]
    end

    ////////////////////////////////////////////////////////////////////////
    // Wake tone and power outputs
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            tone_cnt_r <= '0;
        else if (state_r == pswc_pkg::PSWC_SLEEP && state_nxt != pswc_pkg::PSWC_SLEEP)
            tone_cnt_r <= NW'(TONE_CYC); // [RL19]
        else if (tone_cnt_r != '0)
            tone_cnt_r <= tone_cnt_r - NW'(1);
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            high_side_link_tone <= 1'b0;
        else
            high_side_link_tone <= state_r == pswc_pkg::PSWC_SLEEP &&
                state_nxt != pswc_pkg::PSWC_SLEEP ||
                tone_cnt_r > NW'(1); // [RL19]
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            core_reset_r <= 1'b1;
            awake_r <= 1'b0;
            state_out_r <= 2'h0;
        end
        else
        begin
            core_reset_r <= io_supply_low || state_nxt == pswc_pkg::PSWC_SLEEP; // [RL10] [RL21]
            awake_r <= state_nxt != pswc_pkg::PSWC_SLEEP;
            state_out_r <= state_nxt;
        end
    end
endmodule

// ---- verification/pswc_link_model.sv ----
`timescale 1ns/1ns
module pswc_link_model (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Bench requests
    input wire logic tone_req,
    input wire logic frame_req,
    // Link side
    output logic low_side_link_tone,
    output logic frame_valid,
    output logic comm_busy
);
    logic [3:0] busy_r;
    assign comm_busy = busy_r != 4'h0;
    ////////////////////////////////////////////////////////////////
    // Wake tone from the device below, frames with traffic
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            busy_r <= 4'h0;
            frame_valid <= 1'b0;
            low_side_link_tone <= 1'b0;
        end
        else
        begin
            low_side_link_tone <= tone_req;
            frame_valid <= busy_r == 4'h1;
            if (frame_req && busy_r == 4'h0)
                busy_r <= 4'h8;
            else if (busy_r != 4'h0)
                busy_r <= busy_r - 4'h1;
        end
    end
endmodule

// ---- verification/pswc_core_checker.sv ----
`timescale 1ns/1ns
module pswc_core_checker #(
    parameter int IO_SD_CYC = 500
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Watched inputs
    input wire logic wake_pin,
    input wire logic low_side_link_tone,
    input wire logic comm_busy,
    input wire logic io_supply_low,
    input wire logic main_supply_low,
    input wire logic always_on_5v_supply_low,
    input wire logic thermal_shutdown_sensor_a,
    input wire logic thermal_shutdown_sensor_b,
    // Watched outputs
    input wire logic high_side_link_tone,
    input wire logic core_reset_r,
    input wire logic awake_r,
    input wire logic [1:0] state_out_r
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    int io_cnt;
    always_ff @(posedge clk_sys or posedge rst)
        if (rst)
            io_cnt <= 0;
        else
            io_cnt <= io_supply_low ? io_cnt + 1 : 0;
    ////////////////////////////////////////////////////////////////
    sequence up_no_wake;
        state_out_r != 2'h0 && !wake_pin;
    endsequence
    sequence falls_asleep;
        ##[1:3] state_out_r == 2'h0;
    endsequence
    sequence quiet_sleep;
        state_out_r == 2'h0 && !wake_pin && !$past(wake_pin) && !low_side_link_tone
            && !$past(low_side_link_tone);
    endsequence
    ////////////////////////////////////////////////////////////////
    state_legal_a: assert property (state_out_r != 2'h3)
        else $error("bad state");
    active_ends_a: assert property (
        state_out_r == 2'h2 && !comm_busy |-> ##[1:2] state_out_r != 2'h2)
        else $error("active without traffic");
    pin_wakes_a: assert property (
        state_out_r == 2'h0 && wake_pin && !io_supply_low |-> ##[1:3] state_out_r != 2'h0)
        else $error("no wake");
    sleep_holds_a: assert property (quiet_sleep |=> state_out_r == 2'h0)
        else $error("left sleep");
    tone_on_wake_a: assert property ($rose(awake_r) |-> ##[0:2] high_side_link_tone)
        else $error("no tone");
    thermal_sleep_a: assert property (
        up_no_wake ##0 (thermal_shutdown_sensor_a || thermal_shutdown_sensor_b) |-> falls_asleep)
        else $error("thermal ignored");
    supply_sleep_a: assert property (
        up_no_wake ##0 (main_supply_low || always_on_5v_supply_low) |-> falls_asleep)
        else $error("supply ignored");
    io_reset_a: assert property (io_supply_low |=> core_reset_r)
        else $error("no reset");
    io_sleep_a: assert property (
        io_cnt > IO_SD_CYC + 3 && !wake_pin && !$past(wake_pin) && !low_side_link_tone
            && !$past(low_side_link_tone) |-> state_out_r == 2'h0)
        else $error("io drop ignored");
endmodule
bind pswc_core pswc_core_checker #(.IO_SD_CYC(IO_SD_CYC)) u_pswc_core_checker (.*);

// ---- verification/tb_top.sv ----
`timescale 1ns/1ns
`include "pswc_map.svh"
module tb_top;
    logic clk_sys, rst, avs_read, avs_write, avs_waitrequest, wake_pin, tone_req, frame_req;
    logic low_side_link_tone, frame_valid, comm_busy, comm_bit_error, sys_bit_error;
    logic high_side_link_tone, core_reset_r, awake_r;
    logic [7:0] tone_seen;
    logic [7:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, rd;
    logic [1:0] state_out_r;
    logic [5:0] cause;
    int n_mismatch = 0;
    int n_compared = 0;
    pswc_core #(.TICK_DIV(4), .TONE_CYC(8), .IO_SD_CYC(4), .REG_SD_CYC(4)) u_pswc_core (.*,
        .io_supply_low(cause[0]), .main_supply_low(cause[1]), .digital_supply_low(cause[2]),
        .always_on_5v_supply_low(cause[3]), .thermal_shutdown_sensor_a(cause[4]),
        .thermal_shutdown_sensor_b(cause[5]), .regulator_drive(cause[1]));
    pswc_link_model u_pswc_link_model (.*);
    initial
    begin
        clk_sys = 0;
        forever #5 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys)
        if (high_side_link_tone === 1'b1)
            tone_seen <= tone_seen + 8'h01;
    ////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        @(posedge clk_sys);
        while (avs_waitrequest !== 1'b0)
            @(posedge clk_sys);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic wait_st(input logic [1:0] s, input int max);
        int n;
        n = 0;
        while (state_out_r !== s && n < max)
        begin
            @(posedge clk_sys);
            n++;
        end
        chk(32'(state_out_r), 32'(s));
    endtask
    task automatic pulse_frame();
        frame_req <= 1'b1;
        @(posedge clk_sys);
        frame_req <= 1'b0;
    endtask
    task automatic wake();
        tone_seen <= 8'h00;
        wake_pin <= 1'b1;
        wait_st(2'h1, 20);
        wake_pin <= 1'b0;
        repeat (20) @(posedge clk_sys);
        chk(32'(state_out_r), 32'h1);
        chk(32'(tone_seen), 32'h8);
    endtask
    ////////////////////////////////////////////////////////////////
    task automatic t_reset();
        chk({core_reset_r, awake_r, state_out_r}, 32'h8);
        bus(1'b1, `PSWC_OFS_PERIOD, 32'h5);
        bus(1'b0, `PSWC_OFS_PERIOD, 32'h0);
        chk(rd, 32'h0);
    endtask
    task automatic t_traffic();
        pulse_frame();
        wait_st(2'h2, 10);
        wait_st(2'h1, 20);
    endtask
    task automatic t_arm_mask();
        bus(1'b1, `PSWC_OFS_TEST, 32'h2);
        bus(1'b1, `PSWC_OFS_TEST, 32'h0);
        bus(1'b0, `PSWC_OFS_STATUS, 32'h0);
        chk(rd & 32'h10, 32'h10);
        bus(1'b1, `PSWC_OFS_MASK, 32'h1);
        comm_bit_error <= 1'b1;
        sys_bit_error <= 1'b1;
        @(posedge clk_sys);
        comm_bit_error <= 1'b0;
        sys_bit_error <= 1'b0;
        bus(1'b0, `PSWC_OFS_FAULT, 32'h0);
        chk(rd, 32'h1);
        bus(1'b1, `PSWC_OFS_FAULT, 32'h1);
        bus(1'b0, `PSWC_OFS_FAULT, 32'h0);
        chk(rd, 32'h0);
        bus(1'b0, 8'h1c, 32'h0);
        chk(rd, 32'h0);
    endtask
    task automatic t_count();
        bus(1'b1, `PSWC_OFS_TEST, 32'h1);
        bus(1'b1, `PSWC_OFS_COUNT, 32'h5);
        repeat (10) @(posedge clk_sys);
        bus(1'b0, `PSWC_OFS_COUNT, 32'h0);
        chk(rd, 32'h6);
        pulse_frame();
        repeat (20) @(posedge clk_sys);
        bus(1'b0, `PSWC_OFS_COUNT, 32'h0);
        chk(rd, 32'h6);
        bus(1'b1, `PSWC_OFS_PERIOD, 32'h8);
        bus(1'b1, `PSWC_OFS_COUNT, 32'h7);
        pulse_frame();
        wait_st(2'h0, 40);
    endtask
    task automatic t_reload();
        tone_req <= 1'b1;
        wait_st(2'h1, 20);
        tone_req <= 1'b0;
        bus(1'b1, `PSWC_OFS_PERIOD, 32'h2);
        repeat (6)
        begin
            repeat (600) @(posedge clk_sys);
            pulse_frame();
        end
        repeat (30) @(posedge clk_sys);
        chk(32'(state_out_r), 32'h1);
        wait_st(2'h0, 2300);
    endtask
    task automatic t_rewake();
        wake_pin <= 1'b1;
        wait_st(2'h1, 20);
        bus(1'b1, `PSWC_OFS_CTRL, 32'h1);
        repeat (6) @(posedge clk_sys);
        chk(32'(state_out_r), 32'h1);
        wake_pin <= 1'b0;
        repeat (4) @(posedge clk_sys);
        bus(1'b1, `PSWC_OFS_CTRL, 32'h1);
        wait_st(2'h0, 10);
    endtask
    task automatic t_causes();
        for (int i = 0; i < 6; i++)
        begin
            wake();
            cause <= 6'h1 << i;
            wait_st(2'h0, 30);
            bus(1'b0, `PSWC_OFS_STATUS, 32'h0);
            chk(rd & 32'hc, i >= 4 ? 32'h1 << (i - 2) : 32'h0);
            cause <= 6'h0;
            @(posedge clk_sys);
        end
    endtask
    ////////////////////////////////////////////////////////////////
    task automatic end_of_test();
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial
    begin
        #300000;
        n_mismatch++;
        end_of_test();
    end
    initial
    begin
        {avs_read, avs_write, wake_pin, tone_req, frame_req} = 5'h0;
        {comm_bit_error, sys_bit_error, avs_address, avs_writedata, cause, tone_seen} = '0;
        rst = 1'b1;
        repeat (4) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        t_reset();
        wake();
        t_traffic();
        t_arm_mask();
        t_count();
        t_reload();
        t_rewake();
        t_causes();
        end_of_test();
    end
endmodule
